// File: dct_pkg.sv
// package: register map, fields and encodings of the dual counter/timer
package dct_pkg;
  localparam logic [7:0] CLKSEL_ADDR = 8'h8E;
  localparam logic [7:0] RUNFLG_ADDR = 8'h88;
  localparam logic [7:0] MODE_ADDR   = 8'h89;
  localparam logic [7:0] T0LO_ADDR   = 8'h8A;
  localparam logic [7:0] T1LO_ADDR   = 8'h8B;
  localparam logic [7:0] T0HI_ADDR   = 8'h8C;
  localparam logic [7:0] T1HI_ADDR   = 8'h8D;
  localparam logic [7:0] REG_RESET   = 8'h00;
  // clock select fields
  localparam int T3H_POS = 7;
  localparam int T3L_POS = 6;
  localparam int T2H_POS = 5;
  localparam int T2L_POS = 4;
  localparam int T1S_POS = 3;
  localparam int T0S_POS = 2;
  // run/flag fields
  localparam int TF1_POS = 7;
  localparam int TR1_POS = 6;
  localparam int TF0_POS = 5;
  localparam int TR0_POS = 4;
  // mode register: timer n field at 4*n
  localparam int GATE_OFS = 3;
  localparam int CPIN_OFS = 2;
  // prescaler divisors
  localparam int DIV_A = 12;
  localparam int DIV_B = 4;
  localparam int DIV_C = 48;
  localparam int DIV_X = 8;
  localparam logic [1:0] PS_12 = 2'h0;
  localparam logic [1:0] PS_4  = 2'h1;
  localparam logic [1:0] PS_48 = 2'h2;
  localparam logic [1:0] PS_X8 = 2'h3;
  localparam logic [12:0] MAX13 = 13'h1FFF;
  typedef enum logic [1:0] {M_13BIT, M_16BIT, M_RELOAD, M_SPLIT} dct_mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dct_sfr_req_t;
  typedef struct packed {
    logic tmr0_vector_ack;
    logic tmr1_vector_ack;
  } dct_ack_t;
endpackage : dct_pkg

// File: dct_timers.sv
// timers 0 and 1 with shared prescaler and clock select register
`timescale 1ns/1ps
// Notes on behaviour
// (R1) prescale code picks sysclk/12, /4, /48 or synchronised ext clock/8
// (R2) per-timer select: 1 system clock, 0 prescaled; ignored when counting pins
// (R3) timer 2 low-byte select: 1 system clock, else its own ext choice
// (R4) timer 3 low-byte select: 1 system clock, else its own ext choice
// (R5) split mode high-byte selects of timers 2 and 3 work likewise
// (R6) each timer is 16 bits in separate low and high byte registers
// (R7) mode 0 counts 13 bits: high byte plus low bits 4..0
// (R8) mode 0 wrap 1FFF to 0 sets overflow flag and interrupt request
// (R9) pin-count select: increment on each falling pin edge
// (R10) count only when run and (no gate or gate input active)
// (R11) setting run neither clears nor reloads the count
// (R12) timer 1 mirrors timer 0 using its own bits and gate input
// (R13) mode 1 counts all 16 bits
// (R14) mode 2 low byte counts, reloads from high byte on wrap
// (R15) mode 3 timer 0 low byte is own 8-bit timer with timer 0 bits
// (R16) mode 3 timer 0 high byte: clock only, timer 1 run and flag
// (R17) under timer 0 split, timer 1 no pins, no flag, pulse remains
// (R18) timer 1 mode 3 inactive; under split its mode acts as run
// (R19) mode field: 00 13-bit, 01 16-bit, 10 reload, 11 split/inactive
// (R20) overflow flags writable, cleared on interrupt vector
// (R21) pin levels held two clocks, rate at most quarter of sysclk
// (R22) pins and gate inputs pass a two-stage synchroniser first
// (R23) one-clock overflow pulse per timer for other blocks
module dct_timers
  import dct_pkg::*;
(
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RESET,
  input  wire dct_pkg::dct_sfr_req_t I_SFR,
  input  wire dct_pkg::dct_ack_t     I_ACK,
  input  wire logic                  I_EXT_IRQ_IN_A,
  input  wire logic                  I_EXT_IRQ_IN_B,
  input  wire logic                  I_EXT_IRQ_A_POLARITY,
  input  wire logic                  I_EXT_IRQ_B_POLARITY,
  input  wire logic                  I_TMR0_EVENT_PIN,
  input  wire logic                  I_TMR1_EVENT_PIN,
  input  wire logic                  I_EXT_CLK,
  input  wire logic                  I_TMR0_IRQ_ENABLE,
  input  wire logic                  I_TMR1_IRQ_ENABLE,
  input  wire logic                  I_T2_EXT_CLOCK_CHOICE,
  input  wire logic                  I_T3_EXT_CLOCK_CHOICE,
  output logic [7:0]                 O_SFR_RDATA,
  output logic                       O_TMR0_IRQ,
  output logic                       O_TMR1_IRQ,
  output logic                       O_TMR0_OVF_PULSE,
  output logic                       O_TMR1_OVF_PULSE,
  output logic                       O_T2_LOW_SYSCLK,
  output logic                       O_T2_HIGH_SYSCLK,
  output logic                       O_T3_LOW_SYSCLK,
  output logic                       O_T3_HIGH_SYSCLK
);
  import dct_pkg::*;

  logic [7:0]  clk_sel_q;
  logic [7:0]  mode_q;
  logic        tr0_q, tr1_q, tf0_q, tf1_q;
  logic [7:0]  tl0_q, th0_q, tl1_q, th1_q;
  logic [3:0]  sync1_q, sync2_q;
  logic [1:0]  pin_prev_q;
  logic        xclk_prev_q;
  logic [5:0]  pre_cnt_q;
  logic [2:0]  xclk_cnt_q;
  logic        pre_tick;
  logic        xclk_fall;
  logic        gate_a, gate_b, pin0_fall, pin1_fall;
  logic        en0, en1, en0h;
  logic        inc0, inc1, inc0h;
  logic        ovf0, ovf1, ovf0h;
  logic        t0_split;
  dct_mode_t   m0, m1;
  logic [7:0]  tl0_d, th0_d, tl1_d, th1_d;

  assign m0 = dct_mode_t'(mode_q[1:0]);
  assign m1 = dct_mode_t'(mode_q[5:4]);
  assign t0_split = (m0 == M_SPLIT); // R19

  // two-stage synchroniser: gate a, gate b, pin 0, pin 1 (ext clk separate)
  logic [1:0] xsync_q;
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      xsync_q <= 2'h0;
    end
    else
    begin
      sync1_q <= {I_TMR1_EVENT_PIN, I_TMR0_EVENT_PIN,
                  I_EXT_IRQ_IN_B, I_EXT_IRQ_IN_A}; // R22
      sync2_q <= sync1_q;
      xsync_q <= {xsync_q[0], I_EXT_CLK};
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      pin_prev_q  <= 2'h0;
      xclk_prev_q <= 1'b0;
    end
    else
    begin
      pin_prev_q  <= sync2_q[3:2];
      xclk_prev_q <= xsync_q[1];
    end
  end

  assign gate_a    = (sync2_q[0] == I_EXT_IRQ_A_POLARITY); // R10
  assign gate_b    = (sync2_q[1] == I_EXT_IRQ_B_POLARITY); // R12
  assign pin0_fall = pin_prev_q[0] & ~sync2_q[2]; // R9
  assign pin1_fall = pin_prev_q[1] & ~sync2_q[3]; // R9
  assign xclk_fall = xclk_prev_q & ~xsync_q[1];

  // prescaler
  logic [5:0] pre_lim;
  always_comb
  begin
    unique case (clk_sel_q[1:0]) // R1
      PS_12:   pre_lim = 6'(DIV_A - 1);
      PS_4:    pre_lim = 6'(DIV_B - 1);
      PS_48:   pre_lim = 6'(DIV_C - 1);
      default: pre_lim = 6'h00;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      pre_cnt_q  <= 6'h00;
      xclk_cnt_q <= 3'h0;
    end
    else
    begin
      pre_cnt_q <= (pre_cnt_q >= pre_lim) ? 6'h00 : pre_cnt_q + 6'h01;
      if (xclk_fall)
        xclk_cnt_q <= xclk_cnt_q + 3'h1;
    end
  end

  assign pre_tick = (clk_sel_q[1:0] == PS_X8)
                  ? (xclk_fall && xclk_cnt_q == 3'(DIV_X - 1))
                  : (pre_cnt_q >= pre_lim); // R1

  logic tick0, tick1;
  assign tick0 = clk_sel_q[T0S_POS] ? 1'b1 : pre_tick; // R2
  assign tick1 = clk_sel_q[T1S_POS] ? 1'b1 : pre_tick; // R2

  // run enables
  assign en0  = tr0_q && (!mode_q[GATE_OFS] || gate_a); // R10
  assign en0h = tr1_q; // R16
  assign en1  = t0_split ? (m1 != M_SPLIT) // R18
              : (tr1_q && (!mode_q[4 + GATE_OFS] || gate_b)
                 && m1 != M_SPLIT); // R12

  assign inc0  = en0 && (mode_q[CPIN_OFS] ? pin0_fall : tick0); // R9
  assign inc0h = t0_split && en0h && tick1; // R16
  assign inc1  = en1 && ((mode_q[4 + CPIN_OFS] && !t0_split)
                         ? pin1_fall : tick1); // R17

  // timer datapath (shared by 0 and 1)
  function automatic logic [16:0] step(input dct_mode_t m,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [12:0] c13;
    logic [15:0] c16;
    begin
      c13 = {hi, lo[4:0]} + 13'h0001;
      c16 = {hi, lo} + 16'h0001;
      step = {1'b0, hi, lo};
      unique case (m)
        M_13BIT:  step = {({hi, lo[4:0]} == MAX13), c13[12:5],
                          lo[7:5], c13[4:0]}; // R7 R8
        M_16BIT:  step = {({hi, lo} == 16'hFFFF), c16}; // R13
        M_RELOAD: step = (lo == 8'hFF) ? {1'b1, hi, hi} // R14
                         : {1'b0, hi, lo + 8'h01};
        M_SPLIT:  step = (lo == 8'hFF) ? {1'b1, hi, 8'h00} // R15
                         : {1'b0, hi, lo + 8'h01};
      endcase
    end
  endfunction : step

  logic [16:0] s0, s1;
  assign s0 = step(m0, tl0_q, th0_q);
  assign s1 = step(m1, tl1_q, th1_q);
  assign ovf0  = inc0 && s0[16];
  assign ovf1  = inc1 && s1[16];
  assign ovf0h = inc0h && (th0_q == 8'hFF); // R16

  logic wr_tl0, wr_th0, wr_tl1, wr_th1, wr_run;
  assign wr_tl0 = I_SFR.wr && I_SFR.addr == T0LO_ADDR;
  assign wr_th0 = I_SFR.wr && I_SFR.addr == T0HI_ADDR;
  assign wr_tl1 = I_SFR.wr && I_SFR.addr == T1LO_ADDR;
  assign wr_th1 = I_SFR.wr && I_SFR.addr == T1HI_ADDR;
  assign wr_run = I_SFR.wr && I_SFR.addr == RUNFLG_ADDR;

  always_comb
  begin
    tl0_d = inc0 ? s0[7:0] : tl0_q;
    th0_d = t0_split ? (inc0h ? th0_q + 8'h01 : th0_q)
          : (inc0 ? s0[15:8] : th0_q);
    tl1_d = inc1 ? s1[7:0] : tl1_q;
    th1_d = inc1 ? s1[15:8] : th1_q;
    if (wr_tl0) tl0_d = I_SFR.wdata;
    if (wr_th0) th0_d = I_SFR.wdata;
    if (wr_tl1) tl1_d = I_SFR.wdata;
    if (wr_th1) th1_d = I_SFR.wdata;
  end

  // count registers hold through run toggles
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      tl0_q <= REG_RESET;
      th0_q <= REG_RESET;
      tl1_q <= REG_RESET;
      th1_q <= REG_RESET;
    end
    else
    begin
      tl0_q <= tl0_d; // R6 R11
      th0_q <= th0_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      clk_sel_q <= REG_RESET;
      mode_q    <= REG_RESET;
      tr0_q     <= 1'b0;
      tr1_q     <= 1'b0;
    end
    else
    begin
      if (I_SFR.wr && I_SFR.addr == CLKSEL_ADDR)
        clk_sel_q <= I_SFR.wdata;
      if (I_SFR.wr && I_SFR.addr == MODE_ADDR)
        mode_q <= I_SFR.wdata;
      if (wr_run)
      begin
        tr0_q <= I_SFR.wdata[TR0_POS];
        tr1_q <= I_SFR.wdata[TR1_POS];
      end
    end
  end

  // overflow flags: hardware set wins over clear
  logic set0, set1;
  assign set0 = ovf0;
  assign set1 = t0_split ? ovf0h : ovf1; // R16 R17
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      tf0_q <= 1'b0;
      tf1_q <= 1'b0;
    end
    else
    begin
      if (set0)
        tf0_q <= 1'b1; // R8
      else if (I_ACK.tmr0_vector_ack)
        tf0_q <= 1'b0; // R20
      else if (wr_run)
        tf0_q <= I_SFR.wdata[TF0_POS];
      if (set1)
        tf1_q <= 1'b1;
      else if (I_ACK.tmr1_vector_ack)
        tf1_q <= 1'b0; // R20
      else if (wr_run)
        tf1_q <= I_SFR.wdata[TF1_POS];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_TMR0_OVF_PULSE <= 1'b0;
      O_TMR1_OVF_PULSE <= 1'b0;
    end
    else
    begin
      O_TMR0_OVF_PULSE <= ovf0; // R23
      O_TMR1_OVF_PULSE <= ovf1; // R17 R23
    end
  end

  assign O_TMR0_IRQ = tf0_q && I_TMR0_IRQ_ENABLE; // R8
  assign O_TMR1_IRQ = tf1_q && I_TMR1_IRQ_ENABLE;

  // timer 2/3 clock choice: 1 = system clock, 0 = own ext choice
  assign O_T2_LOW_SYSCLK  = clk_sel_q[T2L_POS] | 1'b0; // R3
  assign O_T3_LOW_SYSCLK  = clk_sel_q[T3L_POS]; // R4
  assign O_T2_HIGH_SYSCLK = clk_sel_q[T2H_POS]; // R5
  assign O_T3_HIGH_SYSCLK = clk_sel_q[T3H_POS]; // R5

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
      O_SFR_RDATA <= 8'h00;
    else if (I_SFR.rd)
    begin
      unique case (I_SFR.addr)
        CLKSEL_ADDR: O_SFR_RDATA <= clk_sel_q;
        RUNFLG_ADDR: O_SFR_RDATA <= {tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
        MODE_ADDR:   O_SFR_RDATA <= mode_q;
        T0LO_ADDR:   O_SFR_RDATA <= tl0_q;
        T0HI_ADDR:   O_SFR_RDATA <= th0_q;
        T1LO_ADDR:   O_SFR_RDATA <= tl1_q;
        T1HI_ADDR:   O_SFR_RDATA <= th1_q;
        default:     O_SFR_RDATA <= 8'h00;
      endcase
    end
  end

  sequence s_wrap13;
    inc0 && m0 == M_13BIT && th0_q == 8'hFF && tl0_q[4:0] == 5'h1F;
  endsequence
  AST_WRAP13: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    s_wrap13 ##1 1'b1 |-> tf0_q && th0_q == 8'h00 && tl0_q[4:0] == 5'h00
                          || $past(wr_th0) || $past(wr_tl0)) // R8
    else $error("mode 0 wrap did not set flag");
  AST_RELOAD: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    inc0 && m0 == M_RELOAD && tl0_q == 8'hFF && !wr_tl0 && !wr_th0
    |=> tl0_q == $past(th0_q) && th0_q == $past(th0_q)) // R14
    else $error("mode 2 reload wrong");
  AST_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    !tr0_q && !wr_tl0 && !wr_th0 && !t0_split |=> $stable(tl0_q)) // R10
    else $error("timer 0 moved while stopped");
  AST_PULSE: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_TMR0_OVF_PULSE |=> !O_TMR0_OVF_PULSE || $past(ovf0)) // R23
    else $error("overflow pulse too long");
  AST_SPLIT_T1: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    t0_split && ovf1 && !ovf0h && !tf1_q && !wr_run |=> !tf1_q) // R17
    else $error("timer 1 set flag in split");
  AST_ACK: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    I_ACK.tmr0_vector_ack && !set0 |=> !tf0_q) // R20
    else $error("vector did not clear flag");
  AST_PIN: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    mode_q[CPIN_OFS] && !pin0_fall |-> !inc0) // R9
    else $error("pin mode counted without edge");
  AST_T1OFF: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    m1 == M_SPLIT |-> !inc1) // R18
    else $error("timer 1 counted in mode 3");
endmodule : dct_timers

// File: dct_core_model.sv
// core and interrupt controller stand-in on the register bus
`timescale 1ns/1ps
module dct_core_model
  import dct_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_irq0,
  input  wire logic             i_irq1,
  input  wire logic [7:0]       i_rdata,
  output dct_pkg::dct_sfr_req_t o_sfr,
  output dct_pkg::dct_ack_t     o_ack
);
  logic ack_en;

  initial
  begin
    o_sfr  = '0;
    o_ack  = '0;
    ack_en = 1'b0;
  end

  // vector once per pending request
  always @(posedge i_clk)
  begin
    o_ack.tmr0_vector_ack <= ack_en & i_irq0 & ~o_ack.tmr0_vector_ack;
    o_ack.tmr1_vector_ack <= ack_en & i_irq1 & ~o_ack.tmr1_vector_ack;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_sfr <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    o_sfr <= '0;
    #1 d = i_rdata;
  endtask : rd
endmodule : dct_core_model

// File: testbench.sv
// self-checking bench for the dual counter/timer block
`timescale 1ns/1ps
module testbench;
  import dct_pkg::*;
  logic         clk;
  logic         rst;
  dct_sfr_req_t sfr;
  dct_ack_t     ack;
  logic [1:0]   gin;
  logic [1:0]   pol;
  logic [1:0]   pin;
  logic         ext_clk;
  logic         ext_on;
  logic [1:0]   ien;
  logic [1:0]   xsel;
  logic [7:0]   rdata;
  logic [1:0]   irq;
  logic [1:0]   ovf;
  logic [3:0]   hsel;
  logic [7:0]   v;
  logic [7:0]   r;
  int           mismatches;
  int           check_count;
  int           cyc;
  int           n;
  int           dv[4] = '{DIV_A, DIV_B, DIV_C, 4 * DIV_X};

  dct_timers u_dut (
    .I_CLK_SYS            (clk),
    .I_RESET              (rst),
    .I_SFR                (sfr),
    .I_ACK                (ack),
    .I_EXT_IRQ_IN_A       (gin[0]),
    .I_EXT_IRQ_IN_B       (gin[1]),
    .I_EXT_IRQ_A_POLARITY (pol[0]),
    .I_EXT_IRQ_B_POLARITY (pol[1]),
    .I_TMR0_EVENT_PIN     (pin[0]),
    .I_TMR1_EVENT_PIN     (pin[1]),
    .I_EXT_CLK            (ext_clk),
    .I_TMR0_IRQ_ENABLE    (ien[0]),
    .I_TMR1_IRQ_ENABLE    (ien[1]),
    .I_T2_EXT_CLOCK_CHOICE(xsel[0]),
    .I_T3_EXT_CLOCK_CHOICE(xsel[1]),
    .O_SFR_RDATA          (rdata),
    .O_TMR0_IRQ           (irq[0]),
    .O_TMR1_IRQ           (irq[1]),
    .O_TMR0_OVF_PULSE     (ovf[0]),
    .O_TMR1_OVF_PULSE     (ovf[1]),
    .O_T2_LOW_SYSCLK      (hsel[0]),
    .O_T2_HIGH_SYSCLK     (hsel[1]),
    .O_T3_LOW_SYSCLK      (hsel[2]),
    .O_T3_HIGH_SYSCLK     (hsel[3])
  );

  dct_core_model u_core (
    .i_clk  (clk),
    .i_irq0 (irq[0]),
    .i_irq1 (irq[1]),
    .i_rdata(rdata),
    .o_sfr  (sfr),
    .o_ack  (ack)
  );

  always #50 clk = ~clk;

  // external clock: falling edge every 4 cycles while enabled
  always
  begin
    repeat (2) @(posedge clk);
    if (ext_on)
      ext_clk <= ~ext_clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("ERROR %0t: %0d cycles outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_core.rd(a, v);
    chk8(v, e);
  endtask : rdc

  function automatic logic [7:0] run_m(input int t);
    return 8'h01 << (t ? TR1_POS : TR0_POS);
  endfunction : run_m

  task automatic load(input int t, input logic [7:0] lo, input logic [7:0] hi);
    u_core.wr(t ? T1LO_ADDR : T0LO_ADDR, lo);
    u_core.wr(t ? T1HI_ADDR : T0HI_ADDR, hi);
  endtask : load

  // cycles until the overflow pulse, then check that it is low one clock later
  task automatic wait_ovf(input int t, output int c);
    c = 0;
    #1;
    while (ovf[t] !== 1'b1 && c < 400)
    begin
      @(posedge clk);
      #1 c++;
    end
    @(posedge clk);
    #1 chk8({7'h00, ovf[t]}, 8'h00);
  endtask : wait_ovf

  task automatic pulses(input int t, input int k);
    repeat (k)
    begin
      pin[t] <= 1'b0;
      repeat (3) @(posedge clk);
      pin[t] <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : pulses

  initial
  begin
    clk = 0; rst = 1; gin = 0; pol = 0; pin = 2'h3; ext_clk = 1;
    ext_on = 0; ien = 2'h3; xsel = 0; mismatches = 0; check_count = 0;
    cyc = 0;
    void'($urandom(99));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    xsel <= 2'($urandom);
    for (int a = 8'h88; a <= 8'h8E; a++)
      rdc(8'(a), REG_RESET);
    u_core.wr(8'h8F, 8'hFF);
    rdc(8'h8F, 8'h00);
    v = 8'($urandom);
    u_core.wr(CLKSEL_ADDR, v);
    rdc(CLKSEL_ADDR, v);
    chk8({4'h0, hsel}, {4'h0, v[7:4]});
    for (int k = 0; k < 4; k++)
    begin
      ext_on <= (k == 3);
      u_core.wr(MODE_ADDR, 8'h01);
      u_core.wr(CLKSEL_ADDR, 8'(k));
      load(0, 8'hFD, 8'hFF);
      u_core.wr(RUNFLG_ADDR, run_m(0));
      wait_ovf(0, n);
      u_core.wr(RUNFLG_ADDR, 8'h00);
      chk_rng(n, 2 * dv[k], 3 * dv[k] + 8);
    end
    u_core.wr(CLKSEL_ADDR, 8'h0C);
    u_core.wr(MODE_ADDR, 8'h00);
    load(0, {3'($urandom_range(0, 6)), 5'h1E}, 8'hFF);
    u_core.wr(RUNFLG_ADDR, run_m(0));
    wait_ovf(0, n);
    chk_rng(n, 1, 6);
    chk8({7'h00, irq[0]}, 8'h01);
    u_core.wr(RUNFLG_ADDR, 8'h00);
    #1 chk8({7'h00, irq[0]}, 8'h00);
    u_core.wr(RUNFLG_ADDR, 8'h01 << TF0_POS);
    #1 chk8({7'h00, irq[0]}, 8'h01);
    u_core.ack_en <= 1'b1;
    for (n = 0; irq[0] !== 1'b0 && n < 20; n++)
      @(posedge clk);
    rdc(RUNFLG_ADDR, 8'h00);
    u_core.ack_en <= 1'b0;
    r = 8'($urandom_range(0, 8'hF0));
    u_core.wr(MODE_ADDR, 8'h02);
    load(0, 8'hFE, r);
    u_core.wr(RUNFLG_ADDR, run_m(0));
    wait_ovf(0, n);
    u_core.wr(RUNFLG_ADDR, 8'h00);
    rdc(T0HI_ADDR, r);
    u_core.rd(T0LO_ADDR, v);
    chk8({7'h00, 8'(v - r) > 8'h06}, 8'h00);
    for (int t = 0; t < 2; t++)
    begin
      v = 8'($urandom);
      pol[t] <= v[0];
      gin[t] <= ~v[0];
      u_core.wr(MODE_ADDR, 8'h09 << (4 * t));
      load(t, 8'hFE, 8'hFF);
      u_core.wr(RUNFLG_ADDR, run_m(t));
      repeat (20) @(posedge clk);
      rdc(t ? T1LO_ADDR : T0LO_ADDR, 8'hFE);
      gin[t] <= pol[t];
      wait_ovf(t, n);
      chk_rng(n, 1, 10);
      u_core.wr(MODE_ADDR, 8'h05 << (4 * t));
      load(t, 8'h00, 8'h00);
      n = $urandom_range(3, 9);
      pulses(t, n);
      repeat (6) @(posedge clk);
      rdc(t ? T1LO_ADDR : T0LO_ADDR, 8'(n));
      u_core.wr(RUNFLG_ADDR, 8'h00);
    end
    u_core.wr(MODE_ADDR, 8'hF3);
    load(1, 8'hFE, 8'hFF);
    load(0, 8'hFD, 8'hFE);
    u_core.wr(RUNFLG_ADDR, run_m(1));
    for (n = 0; irq[1] !== 1'b1 && n < 20; n++)
      @(posedge clk);
    chk8({7'h00, irq[1]}, 8'h01);
    rdc(T0LO_ADDR, 8'hFD);
    rdc(T1LO_ADDR, 8'hFE);
    u_core.wr(RUNFLG_ADDR, run_m(0));
    wait_ovf(0, n);
    chk_rng(n, 1, 8);
    u_core.wr(RUNFLG_ADDR, 8'h00);
    u_core.wr(MODE_ADDR, 8'h13);
    wait_ovf(1, n);
    chk_rng(n, 1, 300);
    rdc(RUNFLG_ADDR, 8'h00);
    final_report();
  end
endmodule : testbench
